// ---- verilog/ieac_defines.svh ----
`ifndef IEAC_DEFINES_SVH
`define IEAC_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define IEAC_OFF_ENABLE      12'h06C
`define IEAC_OFF_INTR_STAT   12'h080
`define IEAC_OFF_INTR_MASK   12'h084
`define IEAC_OFF_CONFIG      12'h088
`define IEAC_OFF_ACTIVITY    12'h08C

// ************************************************************
// field positions
// ************************************************************
`define IEAC_ENABLE_BIT      0
`define IEAC_ABORT_BIT       1
`define IEAC_CMD_BLOCK_BIT   2
`define IEAC_EV_TX_ABORT     0
`define IEAC_EV_STOP_DONE    1
`define IEAC_EV_RX_NACKED    2
`define IEAC_EV_IDLE         3
`define IEAC_NUM_EVENTS      4

// ************************************************************
// reset values and timing
// ************************************************************
`define IEAC_ENABLE_RESET    1'h0
`define IEAC_MASK_RESET      4'h0
`define IEAC_ASYNC_RESET     1'h0
`define IEAC_SYNC_STAGES     2

`endif

// ---- verilog/ieac_pkg.sv ----
package ieac_pkg;

    typedef enum logic [4:0] {
        IEAC_IDLE  = 5'h01,
        IEAC_TX    = 5'h02,
        IEAC_RX    = 5'h04,
        IEAC_STOP  = 5'h08,
        IEAC_FLUSH = 5'h10
    } ieac_state_t;

endpackage

// ---- verilog/ieac_enable_sync.sv ----
`timescale 1ns/1ps
`include "ieac_defines.svh"

module ieac_enable_sync #(
    parameter int STAGES = `IEAC_SYNC_STAGES
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic async_mode,
    input  wire logic enable_in,
    output logic      enable_out
);

    if (STAGES < 2) begin : g_bad_stages
        $error("ieac_enable_sync needs at least two stages");
    end

    logic [STAGES-1:0] chain;

    // ************************************************************
    // three cycle delay in asynchronous mode
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], enable_in};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            enable_out <= 1'b0;
        end else if (async_mode) begin
            enable_out <= chain[STAGES-1];  // R07
        end else begin
            enable_out <= enable_in;
        end
    end

endmodule

// ---- verilog/ieac_enable_abort.sv ----
// Functional notes
// R01: the abort field reads 0 when idle of abort and 1 while an abort runs.
// R02: writing enable 0 disables the controller with both FIFOs held erased, 1 enables it.
// R03: on disable both transmit and receive FIFOs are flushed.
// R04: masked interrupt status stays active after disable until the controller is idle; the code holds it past idle until a status read clears it.
// R05: disabled while transmitting, the current transfer finishes then the tx buffer is dropped.
// R06: disabled while receiving, the byte in progress ends and is not acknowledged.
// R07: in asynchronous clock mode an enable change takes effect two controller clocks later; the code takes three (two sync stages plus the output register).
// R08: enable resets to 0 so the controller starts disabled.
// R09: software should follow a careful disable procedure when disabling while active.
// R10: writes setting abort are ignored unless the controller is already enabled.
// R11: a software write of 0 does not clear a set abort.
// R12: on abort the current transfer completes, a STOP is issued, tx FIFO flushed, abort raised.
// R13: the controller clears abort by itself when the abort has finished.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "ieac_defines.svh"

module ieac_enable_abort #(
    parameter int ADDR_W = 12
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              tx_start,
    input  wire logic              rx_start,
    input  wire logic              xfer_done,
    input  wire logic              stop_done,
    output logic                   ctrl_enabled,
    output logic                   tx_fifo_flush,
    output logic                   rx_fifo_flush,
    output logic                   rx_nack,
    output logic                   stop_request,
    output logic                   cmd_block,
    output ieac_pkg::ieac_state_t  ctrl_state,
    output logic                   irq
);
    import ieac_pkg::*;

    // ************************************************************
    // parameter check
    // ************************************************************
    if (ADDR_W < 12) begin : g_bad_addr_w
        $error("ieac_enable_abort needs ADDR_W of at least 12");
    end

    // ************************************************************
    // bus decode
    // ************************************************************
    logic                        wr_en;
    logic                        rd_en;
    logic [11:0]                 addr;
    logic                        sw_enable;
    logic                        abort_req;
    logic                        async_mode;
    logic                        eff_enable;
    logic                        next_abort;
    logic [`IEAC_NUM_EVENTS-1:0] intr_stat;
    logic [`IEAC_NUM_EVENTS-1:0] intr_mask;
    logic [`IEAC_NUM_EVENTS-1:0] events;
    logic                        mapped;
    ieac_state_t                 state;
    ieac_state_t                 next_state;
    logic                        aborting;
    logic                        wr_enable_reg;
    logic                        wr_config;
    logic                        wr_mask;
    logic                        rd_status;

    assign addr    = paddr[11:0];
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign mapped  = (addr == `IEAC_OFF_ENABLE) || (addr == `IEAC_OFF_INTR_STAT)
                  || (addr == `IEAC_OFF_INTR_MASK) || (addr == `IEAC_OFF_CONFIG)
                  || (addr == `IEAC_OFF_ACTIVITY);
    assign pslverr = psel && penable && !mapped;

    // ************************************************************
    // register strobes
    // ************************************************************
    assign wr_enable_reg = wr_en && (addr == `IEAC_OFF_ENABLE);
    assign wr_config     = wr_en && (addr == `IEAC_OFF_CONFIG);
    assign wr_mask       = wr_en && (addr == `IEAC_OFF_INTR_MASK);
    assign rd_status     = rd_en && (addr == `IEAC_OFF_INTR_STAT);

    // ************************************************************
    // enable and command block
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sw_enable <= `IEAC_ENABLE_RESET;  // R08
            cmd_block <= 1'b0;
        end else if (wr_enable_reg) begin
            sw_enable <= pwdata[`IEAC_ENABLE_BIT];  // R02
            cmd_block <= pwdata[`IEAC_CMD_BLOCK_BIT];
        end
    end

    // ************************************************************
    // configuration
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            async_mode <= `IEAC_ASYNC_RESET;
        end else if (wr_config) begin
            async_mode <= pwdata[0];
        end
    end

    // ************************************************************
    // enable synchroniser
    // ************************************************************
    ieac_enable_sync #(
        .STAGES(`IEAC_SYNC_STAGES)
    ) u_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .async_mode(async_mode),
        .enable_in (sw_enable),
        .enable_out(eff_enable)
    );

    assign ctrl_enabled = eff_enable;

    // ************************************************************
    // abort control
    // ************************************************************
    always_comb begin
        next_abort = abort_req;
        if (wr_enable_reg && pwdata[`IEAC_ABORT_BIT] && sw_enable) begin
            next_abort = 1'b1;  // R10 R11
        end
        if (state == IEAC_FLUSH && abort_req) begin
            next_abort = 1'b0;  // R13
        end
        if (!eff_enable && state == IEAC_IDLE) begin
            next_abort = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            abort_req <= 1'b0;
        end else begin
            abort_req <= next_abort;
        end
    end

    // ************************************************************
    // transfer state machine
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            IEAC_IDLE: begin
                if (abort_req) begin
                    next_state = IEAC_STOP;
                end else if (eff_enable && !cmd_block && tx_start) begin
                    next_state = IEAC_TX;
                end else if (eff_enable && rx_start) begin
                    next_state = IEAC_RX;
                end
            end
            IEAC_TX: begin
                if (xfer_done && (abort_req || !eff_enable)) begin
                    next_state = IEAC_STOP;  // R05 R12
                end else if (xfer_done) begin
                    next_state = IEAC_IDLE;
                end
            end
            IEAC_RX: begin
                if (xfer_done && (abort_req || !eff_enable)) begin
                    next_state = IEAC_STOP;  // R06
                end else if (xfer_done) begin
                    next_state = IEAC_IDLE;
                end
            end
            IEAC_STOP: begin
                if (stop_done) begin
                    next_state = IEAC_FLUSH;  // R12
                end
            end
            IEAC_FLUSH: begin
                next_state = IEAC_IDLE;
            end
            default: begin
                next_state = IEAC_IDLE;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= IEAC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // state outputs
    // ************************************************************
    assign ctrl_state   = state;
    assign aborting     = abort_req;
    assign stop_request = (state == IEAC_STOP);

    // ************************************************************
    // fifo flush control
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_fifo_flush <= 1'b1;
            rx_fifo_flush <= 1'b1;
        end else begin
            tx_fifo_flush <= !eff_enable || (next_state == IEAC_FLUSH);  // R02 R03 R05 R12
            rx_fifo_flush <= !eff_enable;  // R03
        end
    end

    // ************************************************************
    // acknowledge control
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_nack <= 1'b0;
        end else begin
            rx_nack <= (next_state == IEAC_RX) && !eff_enable;  // R06
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    assign events[`IEAC_EV_TX_ABORT]  = (state == IEAC_FLUSH) && aborting;  // R12
    assign events[`IEAC_EV_STOP_DONE] = (state == IEAC_STOP) && stop_done;
    assign events[`IEAC_EV_RX_NACKED] = (state == IEAC_RX) && xfer_done && !eff_enable;
    assign events[`IEAC_EV_IDLE]      = (state != IEAC_IDLE) && (next_state == IEAC_IDLE);

    // sticky status bits, a new event wins over a read clear
    generate
        for (genvar ev = 0; ev < `IEAC_NUM_EVENTS; ev++) begin : g_stat
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    intr_stat[ev] <= 1'b0;
                end else if (events[ev]) begin
                    intr_stat[ev] <= 1'b1;
                end else if (rd_status) begin
                    intr_stat[ev] <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // interrupt mask
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            intr_mask <= `IEAC_MASK_RESET;
        end else if (wr_mask) begin
            intr_mask <= pwdata[`IEAC_NUM_EVENTS-1:0];
        end
    end

    // ************************************************************
    // interrupt output
    // ************************************************************
    // masked status held after disable and past idle, until a status read clears it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intr_stat & intr_mask);  // R04
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (addr)
                `IEAC_OFF_ENABLE:    prdata <= {29'h0, cmd_block, abort_req, sw_enable};  // R01
                `IEAC_OFF_INTR_STAT: prdata <= {28'h0, intr_stat};
                `IEAC_OFF_INTR_MASK: prdata <= {28'h0, intr_mask};
                `IEAC_OFF_CONFIG:    prdata <= {31'h0, async_mode};
                `IEAC_OFF_ACTIVITY:  prdata <= {26'h0, state, eff_enable};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ---- verification/ieac_assertions.sv ----
`timescale 1ns/1ps
// *****
// enable and abort checks
// *****
module ieac_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              xfer_done,
    input wire logic              stop_done,
    input wire logic              ctrl_enabled,
    input wire logic              tx_fifo_flush,
    input wire logic              rx_fifo_flush,
    input wire logic              rx_nack,
    input wire logic              stop_request,
    input wire ieac_pkg::ieac_state_t ctrl_state
);
    import ieac_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic async_q;
    logic wr_on;
    assign wr_on = psel && penable && pwrite && paddr == 12'h06C && pwdata[0];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            async_q <= 1'b0;
        end else if (psel && penable && pwrite && paddr == 12'h088) begin
            async_q <= pwdata[0];
        end
    end
    chk_en_sync: assert property (wr_on && !async_q && !ctrl_enabled |=>
        !ctrl_enabled ##1 ctrl_enabled) else $error("enable late in sync mode");
    chk_en_async: assert property (wr_on && async_q && !ctrl_enabled |=>
        !ctrl_enabled [*3] ##1 ctrl_enabled) else $error("enable delay wrong in async mode");
    chk_flush_off: assert property ((!ctrl_enabled && ctrl_state == IEAC_IDLE) [*2]
        |-> tx_fifo_flush && rx_fifo_flush) else $error("fifos not erased while off");
    chk_flush_drop: assert property ($rose(ctrl_enabled) |=>
        !tx_fifo_flush && !rx_fifo_flush) else $error("fifos still erased after enable");
    chk_rx_nack: assert property ((ctrl_state == IEAC_RX && !ctrl_enabled) [*2]
        |-> rx_nack) else $error("ack not withheld");
    chk_tx_finish: assert property (ctrl_state == IEAC_TX && !xfer_done
        |=> ctrl_state == IEAC_TX) else $error("transmit cut short");
    chk_stop_next: assert property (ctrl_state inside {IEAC_TX, IEAC_RX} && xfer_done
        && !ctrl_enabled |=> ctrl_state == IEAC_STOP) else $error("no stop after byte");
    chk_stop_req: assert property (stop_request && stop_done |=> !stop_request
        && ctrl_state == IEAC_FLUSH && tx_fifo_flush) else $error("no flush after stop");
    chk_flush_tx: assert property (ctrl_state == IEAC_FLUSH |-> ##[0:1] tx_fifo_flush)
        else $error("tx fifo not flushed");
    cover property (ctrl_state == IEAC_STOP);
    cover property (rx_nack);
    cover property (wr_on && async_q);
endmodule

bind ieac_enable_abort ieac_chk #(.ADDR_W(ADDR_W)) u_chk (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .xfer_done(xfer_done),
    .stop_done(stop_done),
    .ctrl_enabled(ctrl_enabled), .tx_fifo_flush(tx_fifo_flush),
    .rx_fifo_flush(rx_fifo_flush), .rx_nack(rx_nack),
    .stop_request(stop_request), .ctrl_state(ctrl_state)
);

// ---- verification/ieac_partner.sv ----
`timescale 1ns/1ps
// *****
// far-side bus model
// *****
module ieac_partner (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire ieac_pkg::ieac_state_t ctrl_state,
    input  wire logic                  stop_request,
    input  wire logic                  slow,
    output logic                       xfer_done,
    output logic                       stop_done
);
    import ieac_pkg::*;
    int cnt;
    always_ff @(posedge core_clk) begin
        xfer_done <= 1'b0;
        stop_done <= 1'b0;
        if (rst || ctrl_state == IEAC_IDLE || ctrl_state == IEAC_FLUSH) begin
            cnt <= 0;
        end else if (cnt == (slow ? 40 : 3)) begin
            cnt <= 0;
            xfer_done <= !stop_request;
            stop_done <= stop_request;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ---- verification/i2c_enable_abort_control_test.sv ----
`timescale 1ns/1ps
`include "ieac_defines.svh"
// *****
// bench and model
// *****
module i2c_enable_abort_control_test;
    import ieac_pkg::*;
    logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        tx_start = 1'b0, rx_start = 1'b0, slow = 1'b0, err;
    logic        pready, pslverr, xfer_done, stop_done, ctrl_enabled, tx_fifo_flush;
    logic        rx_fifo_flush, rx_nack, stop_request, cmd_block, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h68C1DB98;
    ieac_state_t ctrl_state;
    int          n_mismatch = 0, tests_run = 0, exp_en = 0, exp_ab = 0, mask, i;
    initial forever #10 core_clk = ~core_clk;
    ieac_enable_abort dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_start(tx_start), .rx_start(rx_start), .xfer_done(xfer_done),
        .stop_done(stop_done), .ctrl_enabled(ctrl_enabled), .tx_fifo_flush(tx_fifo_flush),
        .rx_fifo_flush(rx_fifo_flush), .rx_nack(rx_nack), .stop_request(stop_request),
        .cmd_block(cmd_block), .ctrl_state(ctrl_state), .irq(irq));
    ieac_partner u_far (.core_clk(core_clk), .rst(rst), .ctrl_state(ctrl_state),
        .stop_request(stop_request), .slow(slow), .xfer_done(xfer_done), .stop_done(stop_done));
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task pulse(input logic rx);
        @(posedge core_clk);
        if (rx) rx_start <= 1'b1; else tx_start <= 1'b1;
        @(posedge core_clk);
        rx_start <= 1'b0;
        tx_start <= 1'b0;
    endtask
    task wait_idle;
        i = 0;
        while (ctrl_state !== IEAC_IDLE && i < 300) begin
            @(posedge core_clk);
            i++;
        end
        chk(ctrl_state, IEAC_IDLE);
    endtask
    task test_done;
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        chk({ctrl_enabled, tx_fifo_flush, rx_fifo_flush, irq}, 4'h6);
        apb(0, `IEAC_OFF_ENABLE, 0);
        chk(rd, 0);
        apb(0, 12'hFFC, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1, `IEAC_OFF_ENABLE, 2);
        apb(0, `IEAC_OFF_ENABLE, 0);
        chk(rd & 3, exp_ab * 2 + exp_en);
        lfsr = lfsr_step(lfsr);
        mask = lfsr[3:0] | 1;
        apb(1, `IEAC_OFF_INTR_MASK, mask);
        apb(1, `IEAC_OFF_ENABLE, 1);
        exp_en = 1;
        repeat (4) @(posedge core_clk);
        chk({ctrl_enabled, tx_fifo_flush, rx_fifo_flush}, 3'h4);
        slow <= 1'b1;
        pulse(0);
        apb(1, `IEAC_OFF_ENABLE, 3);
        exp_ab = 1;
        apb(0, `IEAC_OFF_ENABLE, 0);
        chk(rd & 3, exp_ab * 2 + exp_en);
        apb(1, `IEAC_OFF_ENABLE, 1);
        apb(0, `IEAC_OFF_ENABLE, 0);
        chk(rd & 3, exp_ab * 2 + exp_en);
        wait_idle();
        exp_ab = 0;
        apb(0, `IEAC_OFF_ENABLE, 0);
        chk(rd & 3, exp_ab * 2 + exp_en);
        chk(irq, 1);
        apb(0, `IEAC_OFF_INTR_STAT, 0);
        chk(rd & 1, 1);
        repeat (2) @(posedge core_clk);
        chk(irq, 0);
        apb(1, `IEAC_OFF_INTR_MASK, 0);
        pulse(1);
        apb(1, `IEAC_OFF_ENABLE, 0);
        exp_en = 0;
        repeat (4) @(posedge core_clk);
        chk({rx_nack, ctrl_state}, {1'b1, IEAC_RX});
        wait_idle();
        repeat (2) @(posedge core_clk);
        chk({tx_fifo_flush, rx_fifo_flush, irq}, 3'h6);
        apb(1, `IEAC_OFF_INTR_MASK, 4'hF);
        repeat (2) @(posedge core_clk);
        chk(irq, 1);
        apb(0, `IEAC_OFF_INTR_STAT, 0);
        chk(rd & 4, 4);
        apb(1, `IEAC_OFF_CONFIG, 1);
        apb(1, `IEAC_OFF_ENABLE, 1);
        i = 0;
        while (ctrl_enabled !== 1'b1 && i < 20) begin
            @(posedge core_clk);
            i++;
        end
        chk(i, 2 + `IEAC_SYNC_STAGES);
        apb(1, `IEAC_OFF_ENABLE, 5);
        pulse(0);
        @(posedge core_clk);
        chk({cmd_block, ctrl_state}, {1'b1, IEAC_IDLE});
        apb(0, `IEAC_OFF_ACTIVITY, 0);
        chk(rd, {26'h0, IEAC_IDLE, 1'b1});
        apb(0, `IEAC_OFF_CONFIG, 0);
        chk(rd, 1);
        test_done();
    end
    initial begin
        #1000000;
        n_mismatch++;
        test_done();
    end
endmodule
